// ---- hdl/asu_defines.svh ----
// constants of the async serial unit: register offsets, field positions, reset values, counts
// assumes inclusion by bare name from the package and the design modules
`ifndef ASU_DEFINES_SVH
`define ASU_DEFINES_SVH

`define ASU_OFS_CTRL_ONE 5'h00
`define ASU_OFS_CTRL_TWO 5'h04
`define ASU_OFS_CTRL_THREE 5'h08
`define ASU_OFS_STATUS_ONE 5'h0C
`define ASU_OFS_STATUS_TWO 5'h10
`define ASU_OFS_DATA_BUF 5'h14
`define ASU_OFS_BAUD 5'h18

// control_one
`define ASU_B_MOD_EN 0
`define ASU_B_CHAR9 1
`define ASU_B_TX_INV 2
// control_two
`define ASU_B_TX_ON 0
`define ASU_B_RX_ON 1
`define ASU_B_SEND_BRK 2
`define ASU_B_TXE_IE 3
`define ASU_B_RXF_IE 4
// control_three
`define ASU_B_TX_NINE 0
`define ASU_B_RX_NINE 1
// status_one
`define ASU_B_TXE 0
`define ASU_B_RXF 1
`define ASU_B_FE 2
`define ASU_B_OVR 3
`define ASU_B_NF 4
`define ASU_B_PE 5
// status_two
`define ASU_B_BRK 0
`define ASU_B_RX_ACT 1
// baud_reg
`define ASU_B_LONG_BRK 0
`define ASU_B_SRC_SEL 1
`define ASU_F_DIV_LSB 8
`define ASU_F_DIV_MSB 15

`define ASU_RST_DIV 8'h1A
`define ASU_RT_PER_BIT 16
`define ASU_LAST_PHASE 4'hF
`define ASU_RT_SMP_A 4'h7
`define ASU_RT_SMP_C 4'h9
`define ASU_RT_DECIDE 4'hA
`define ASU_LEN_8 4'hA
`define ASU_LEN_9 4'hB

`endif

// ---- hdl/asu_pkg.sv ----
// types of the async serial unit
// assumes asu_defines.svh is on the include path
package asu_pkg;
   `include "asu_defines.svh"

   typedef enum logic [1:0] {
      ASU_TX_IDLE = 2'b00,
      ASU_TX_PRE = 2'b01,
      ASU_TX_DATA = 2'b11,
      ASU_TX_BRK = 2'b10
   } asu_tx_state_type;

   typedef enum logic [1:0] {
      ASU_RX_IDLE = 2'b00,
      ASU_RX_FRAME = 2'b01,
      ASU_RX_WAIT_HI = 2'b11
   } asu_rx_state_type;

   typedef logic [7:0] asu_div_type;
endpackage

// ---- hdl/asu_baud_if.sv ----
// shared baud timing between the unit core and its rate generator
// assumes both ends on clk_sys_i
`timescale 1ns/1ps
interface asu_baud_if;
   import asu_pkg::*;
   asu_div_type div;
   logic src_sel;
   logic alt_tick;
   logic run;
   logic rt_tick;
   modport gen (input div, input src_sel, input alt_tick, input run, output rt_tick);
   modport user (output div, output src_sel, output alt_tick, output run, input rt_tick);
endinterface

// ---- hdl/asu_baud_gen.sv ----
// 16x sampling-rate tick generator shared by transmitter and receiver
// assumes alt_tick is a one-cycle strobe from logic on clk_sys_i
`timescale 1ns/1ps
module asu_baud_gen (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ce_i,
   asu_baud_if.gen bif
);
   import asu_pkg::*;
   asu_div_type cnt_r;
   logic tick_r;
   logic step;

   // source select: every system clock or only the alternate strobes
   assign step = bif.src_sel ? bif.alt_tick : 1'b1;
   assign bif.rt_tick = tick_r;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnt_r <= 8'h00;
         tick_r <= 1'b0;
      end else if (ce_i) begin
         tick_r <= 1'b0;
         if (!bif.run) begin
            cnt_r <= 8'h00;
         end else if (step) begin
            // a divisor of zero behaves as one
            if (cnt_r + 8'h01 >= bif.div) begin
               cnt_r <= 8'h00;
               tick_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 8'h01;
            end
         end
      end
   end
endmodule

// ---- hdl/asu_top.sv ----
// async serial unit: avalon-mm registers, nrz transmitter with break/idle, receiver
// assumes a synchronous avalon master on clk_sys_i; serial_in_i is asynchronous
`timescale 1ns/1ps
`include "asu_defines.svh"
module asu_top (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic baud_alt_tick_i,
   input wire logic serial_in_i,
   output logic serial_out_o,
   output logic serial_out_oe_o,
   output logic tx_irq_o,
   output logic rx_irq_o
);
   import asu_pkg::*;

   asu_baud_if bif ();
   asu_baud_gen u_baud (
      .clk_sys_i (clk_sys_i),
      .rst_i (rst_i),
      .ce_i (ce_i),
      .bif (bif)
   );

   // register state
   logic mod_en_r, char9_r, tx_inv_r;
   logic tx_on_r, rx_on_r, send_brk_r, txe_ie_r, rxf_ie_r;
   logic tx_nine_r, rx_nine_r, long_brk_r, src_sel_r;
   asu_div_type div_r;
   logic [7:0] tx_buf_r, rx_buf_r;
   logic txe_r, rxf_r, fe_r, ovr_r, nf_r, brk_flag_r;
   logic tx_arm_r, rx_arm_r, ack_r;
   logic [31:0] rdata_r;

   // bus decode
   logic req, acc, wr_acc, rd_acc, wr_lo, be_lo;
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & !(ack_r & ce_i);
   assign acc = req & ack_r & ce_i;
   assign wr_acc = acc & avs_write_i;
   assign rd_acc = acc & avs_read_i;
   assign be_lo = avs_byteenable_i[0];
   assign wr_lo = wr_acc & be_lo;
   assign avs_readdata_o = rdata_r;

   // transmitter / receiver events seen by the registers
   logic load_data, rx_done, rx_brk, rx_fe, rx_noise, rx_act;
   logic [8:0] rx_sh_r;
   logic data_wr, data_rd, st1_rd;
   assign data_wr = wr_lo & (avs_address_i == `ASU_OFS_DATA_BUF);
   assign data_rd = rd_acc & (avs_address_i == `ASU_OFS_DATA_BUF);
   assign st1_rd = rd_acc & (avs_address_i == `ASU_OFS_STATUS_ONE);

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else if (ce_i) begin
         ack_r <= req & !ack_r;
      end
   end

   // read data captured in the wait cycle so it stands at the accepting edge
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (ce_i && avs_read_i && !ack_r) begin
         rdata_r <= 32'h0000_0000;
         case (avs_address_i)
            `ASU_OFS_CTRL_ONE: begin
               rdata_r[`ASU_B_MOD_EN] <= mod_en_r;
               rdata_r[`ASU_B_CHAR9] <= char9_r;
               rdata_r[`ASU_B_TX_INV] <= tx_inv_r;
            end
            `ASU_OFS_CTRL_TWO: begin
               rdata_r[`ASU_B_TX_ON] <= tx_on_r;
               rdata_r[`ASU_B_RX_ON] <= rx_on_r;
               rdata_r[`ASU_B_SEND_BRK] <= send_brk_r;
               rdata_r[`ASU_B_TXE_IE] <= txe_ie_r;
               rdata_r[`ASU_B_RXF_IE] <= rxf_ie_r;
            end
            `ASU_OFS_CTRL_THREE: begin
               rdata_r[`ASU_B_TX_NINE] <= tx_nine_r;
               rdata_r[`ASU_B_RX_NINE] <= rx_nine_r;
            end
            `ASU_OFS_STATUS_ONE: begin
               rdata_r[`ASU_B_TXE] <= txe_r;
               rdata_r[`ASU_B_RXF] <= rxf_r;
               rdata_r[`ASU_B_FE] <= fe_r;
               rdata_r[`ASU_B_OVR] <= ovr_r;
               rdata_r[`ASU_B_NF] <= nf_r;
            end
            `ASU_OFS_STATUS_TWO: begin
               rdata_r[`ASU_B_BRK] <= brk_flag_r;
               rdata_r[`ASU_B_RX_ACT] <= rx_act;
            end
            `ASU_OFS_DATA_BUF: rdata_r[7:0] <= rx_buf_r;
            `ASU_OFS_BAUD: begin
               rdata_r[`ASU_B_LONG_BRK] <= long_brk_r;
               rdata_r[`ASU_B_SRC_SEL] <= src_sel_r;
               rdata_r[`ASU_F_DIV_MSB:`ASU_F_DIV_LSB] <= div_r;
            end
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // control registers
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         {mod_en_r, char9_r, tx_inv_r} <= 3'h0;
         {tx_on_r, rx_on_r, send_brk_r, txe_ie_r, rxf_ie_r} <= 5'h00;
         {tx_nine_r, long_brk_r, src_sel_r} <= 3'h0;
         div_r <= `ASU_RST_DIV;
      end else if (ce_i && wr_acc) begin
         case (avs_address_i)
            `ASU_OFS_CTRL_ONE: if (be_lo) begin
               mod_en_r <= avs_writedata_i[`ASU_B_MOD_EN];
               char9_r <= avs_writedata_i[`ASU_B_CHAR9];
               tx_inv_r <= avs_writedata_i[`ASU_B_TX_INV];
            end
            `ASU_OFS_CTRL_TWO: if (be_lo) begin
               tx_on_r <= avs_writedata_i[`ASU_B_TX_ON];
               rx_on_r <= avs_writedata_i[`ASU_B_RX_ON];
               send_brk_r <= avs_writedata_i[`ASU_B_SEND_BRK];
               txe_ie_r <= avs_writedata_i[`ASU_B_TXE_IE];
               rxf_ie_r <= avs_writedata_i[`ASU_B_RXF_IE];
            end
            `ASU_OFS_CTRL_THREE: if (be_lo) begin
               tx_nine_r <= avs_writedata_i[`ASU_B_TX_NINE];
            end
            `ASU_OFS_BAUD: begin
               if (be_lo) begin
                  long_brk_r <= avs_writedata_i[`ASU_B_LONG_BRK];
                  src_sel_r <= avs_writedata_i[`ASU_B_SRC_SEL];
               end
               if (avs_byteenable_i[1]) begin
                  div_r <= avs_writedata_i[`ASU_F_DIV_MSB:`ASU_F_DIV_LSB];
               end
            end
            default: ;
         endcase
      end
   end

   // one generator feeds both directions
   assign bif.div = div_r;
   assign bif.src_sel = src_sel_r;
   assign bif.alt_tick = baud_alt_tick_i;
   assign bif.run = mod_en_r;

   // ---------------- transmitter ----------------
   asu_tx_state_type tx_st_r;
   logic [11:0] tx_sh_r;
   logic [3:0] tx_left_r, tx_phase_r, frame_len;
   logic tx_on_d_r, idle_pend_r, bit_tick, tx_line, frame_end;
   assign frame_len = char9_r ? `ASU_LEN_9 : `ASU_LEN_8;
   assign bit_tick = bif.rt_tick & (tx_phase_r == `ASU_LAST_PHASE);
   assign frame_end = (tx_st_r == ASU_TX_IDLE) | (tx_left_r == 4'h1);
   assign load_data = bit_tick & frame_end & mod_en_r & tx_on_r & !idle_pend_r &
      !(send_brk_r | (tx_st_r == ASU_TX_BRK)) & !txe_r;
   assign tx_line = (tx_st_r == ASU_TX_IDLE) ? 1'b1 : tx_sh_r[0];

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tx_phase_r <= 4'h0;
      end else if (ce_i && bif.rt_tick) begin
         tx_phase_r <= tx_phase_r + 4'h1;
      end
   end

   // rising enable asks for an idle character: preamble when quiet, queued when busy
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tx_on_d_r <= 1'b0;
         idle_pend_r <= 1'b0;
      end else if (ce_i) begin
         tx_on_d_r <= tx_on_r;
         if (!mod_en_r) begin
            idle_pend_r <= 1'b0;
         end else if (tx_on_r && !tx_on_d_r) begin
            idle_pend_r <= 1'b1;
         end else if (bit_tick && frame_end && !send_brk_r && tx_st_r != ASU_TX_BRK) begin
            idle_pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tx_st_r <= ASU_TX_IDLE;
         tx_sh_r <= 12'hFFF;
         tx_left_r <= 4'h0;
      end else if (ce_i && bit_tick) begin
         if (!frame_end) begin
            tx_sh_r <= {1'b1, tx_sh_r[11:1]};
            tx_left_r <= tx_left_r - 4'h1;
         end else if (!mod_en_r) begin
            tx_st_r <= ASU_TX_IDLE;
            tx_left_r <= 4'h0;
         end else if (tx_st_r == ASU_TX_BRK && !send_brk_r) begin
            // one mark bit so the next start edge is seen
            tx_st_r <= ASU_TX_DATA;
            tx_sh_r <= 12'hFFF;
            tx_left_r <= 4'h1;
         end else if (send_brk_r && tx_on_r) begin
            tx_st_r <= ASU_TX_BRK;
            tx_sh_r <= 12'h000;
            tx_left_r <= frame_len + {3'h0, long_brk_r};
         end else if (idle_pend_r) begin
            tx_st_r <= ASU_TX_PRE;
            tx_sh_r <= 12'hFFF;
            tx_left_r <= frame_len;
         end else if (load_data) begin
            tx_st_r <= ASU_TX_DATA;
            // stop one at the top, start zero at the bottom
            tx_sh_r <= char9_r ? {2'b11, tx_nine_r, tx_buf_r, 1'b0}
               : {3'b111, tx_buf_r, 1'b0};
            tx_left_r <= frame_len;
         end else begin
            tx_st_r <= ASU_TX_IDLE;
            tx_left_r <= 4'h0;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         serial_out_o <= 1'b1;
         serial_out_oe_o <= 1'b0;
      end else if (ce_i) begin
         serial_out_o <= tx_line ^ tx_inv_r;
         serial_out_oe_o <= mod_en_r;
      end
   end

   // ---------------- receiver ----------------
   asu_rx_state_type rx_st_r;
   logic rx_s1_r, rx_s2_r, rx_ext_r, rx_zero_r, rx_nz_r, rx_bit, decide;
   logic [2:0] rx_smp_r;
   logic [3:0] rx_rt_r, rx_idx_r, stop_idx;
   assign rx_bit = (rx_smp_r[0] & rx_smp_r[1]) | (rx_smp_r[0] & rx_smp_r[2]) |
      (rx_smp_r[1] & rx_smp_r[2]);
   assign decide = bif.rt_tick & (rx_st_r == ASU_RX_FRAME) & (rx_rt_r == `ASU_RT_DECIDE);
   assign stop_idx = frame_len - 4'h1;
   assign rx_act = (rx_st_r == ASU_RX_FRAME);

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else if (ce_i) begin
         rx_s1_r <= serial_in_i;
         rx_s2_r <= rx_s1_r;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rx_st_r <= ASU_RX_IDLE;
         {rx_rt_r, rx_idx_r} <= 8'h00;
         {rx_smp_r, rx_ext_r, rx_zero_r, rx_nz_r} <= 6'h00;
         rx_sh_r <= 9'h000;
      end else if (ce_i && (!mod_en_r || !rx_on_r)) begin
         rx_st_r <= ASU_RX_IDLE;
      end else if (ce_i && bif.rt_tick) begin
         rx_rt_r <= rx_rt_r + 4'h1;
         if (rx_rt_r >= `ASU_RT_SMP_A && rx_rt_r <= `ASU_RT_SMP_C) begin
            rx_smp_r <= {rx_smp_r[1:0], rx_s2_r};
         end
         case (rx_st_r)
            ASU_RX_IDLE: if (!rx_s2_r) begin
               rx_st_r <= ASU_RX_FRAME;
               {rx_rt_r, rx_idx_r} <= 8'h00;
               {rx_ext_r, rx_nz_r} <= 2'b00;
               rx_zero_r <= 1'b1;
            end
            ASU_RX_FRAME: if (decide) begin
               rx_idx_r <= rx_idx_r + 4'h1;
               rx_nz_r <= rx_nz_r | (rx_smp_r != 3'h0 && rx_smp_r != 3'h7);
               if (rx_idx_r == 4'h0) begin
                  if (rx_bit) begin
                     rx_st_r <= ASU_RX_IDLE;
                  end
               end else if (rx_idx_r < stop_idx) begin
                  rx_sh_r[rx_idx_r - 4'h1] <= rx_bit;
                  rx_zero_r <= rx_zero_r & !rx_bit;
               end else if (rx_idx_r == stop_idx && !rx_bit && long_brk_r && rx_zero_r) begin
                  rx_ext_r <= 1'b1;
               end else begin
                  rx_st_r <= ASU_RX_WAIT_HI;
               end
            end
            ASU_RX_WAIT_HI: if (rx_s2_r) begin
               rx_st_r <= ASU_RX_IDLE;
            end
            default: rx_st_r <= ASU_RX_IDLE;
         endcase
      end
   end

   // a break needs the extended zero in long mode, the plain stop zero otherwise
   assign rx_done = ce_i & decide & (rx_idx_r != 4'h0) & (rx_idx_r >= stop_idx) &
      !(rx_idx_r == stop_idx && !rx_bit && long_brk_r && rx_zero_r);
   assign rx_fe = rx_ext_r | !rx_bit;
   assign rx_brk = rx_zero_r & !rx_bit & (rx_ext_r | !long_brk_r);
   assign rx_noise = rx_nz_r | (rx_smp_r != 3'h0 && rx_smp_r != 3'h7);

   // ---------------- status and buffers ----------------
   // clears need a status_one read first, except brk, cleared by a one written to status_two; a hardware set in the same cycle wins
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tx_arm_r <= 1'b0;
         rx_arm_r <= 1'b0;
         tx_buf_r <= 8'h00;
         txe_r <= 1'b1;
      end else if (ce_i) begin
         if (st1_rd) begin
            tx_arm_r <= 1'b1;
            rx_arm_r <= 1'b1;
         end else begin
            if (data_wr) tx_arm_r <= 1'b0;
            if (data_rd) rx_arm_r <= 1'b0;
         end
         if (data_wr) begin
            tx_buf_r <= avs_writedata_i[7:0];
         end
         if (load_data) begin
            txe_r <= 1'b1;
         end else if (data_wr && tx_arm_r) begin
            txe_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         {rxf_r, fe_r, ovr_r, nf_r, brk_flag_r, rx_nine_r} <= 6'h00;
         rx_buf_r <= 8'h00;
      end else if (ce_i) begin
         if (rx_done) begin
            rxf_r <= 1'b1;
            fe_r <= rx_fe;
            nf_r <= rx_noise;
            ovr_r <= rxf_r && !(data_rd && rx_arm_r);
            if (rx_brk) begin
               brk_flag_r <= 1'b1;
               rx_buf_r <= 8'h00;
               rx_nine_r <= 1'b0;
            end else if (!rxf_r || (data_rd && rx_arm_r)) begin
               rx_buf_r <= rx_sh_r[7:0];
               rx_nine_r <= char9_r ? rx_sh_r[8] : rx_sh_r[7];
            end
         end else if (data_rd && rx_arm_r) begin
            {rxf_r, fe_r, ovr_r, nf_r} <= 4'h0;
         end
         if (!rx_done && wr_lo && avs_address_i == `ASU_OFS_STATUS_TWO &&
               avs_writedata_i[`ASU_B_BRK]) begin
            brk_flag_r <= 1'b0;
         end
      end
   end

   assign tx_irq_o = txe_r & txe_ie_r;
   assign rx_irq_o = rxf_r & rxf_ie_r;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   a_pins_release: assert property (ce_i && !mod_en_r |=> !serial_out_oe_o)
      else $error("serial pin still driven with module disabled");
   a_idle_high: assert property (ce_i && tx_st_r == ASU_TX_IDLE
      |=> serial_out_o == !$past(tx_inv_r))
      else $error("serial_out not idle while quiet");
   a_start_zero: assert property (ce_i && load_data |=> tx_line == 1'b0 && txe_r)
      else $error("start bit or empty flag wrong after load");
   a_bit_hold: assert property (ce_i && !bit_tick |=> $stable(tx_line))
      else $error("transmit bit changed inside a baud period");
   a_break_zero: assert property (tx_st_r == ASU_TX_BRK |-> tx_line == 1'b0)
      else $error("break character carries a one");
   a_mark_after_break: assert property (ce_i && bit_tick && frame_end && mod_en_r &&
      tx_st_r == ASU_TX_BRK && !send_brk_r |=> tx_line == 1'b1)
      else $error("no mark bit after break");
   a_inv_out: assert property (ce_i && $past(ce_i) ##1 ce_i
      |-> serial_out_o == ($past(tx_line) ^ $past(tx_inv_r)))
      else $error("output polarity wrong");
   a_rx_break: assert property (rx_done && rx_brk
      |=> fe_r && rxf_r && brk_flag_r && rx_buf_r == 8'h00 && !rx_nine_r)
      else $error("break reception flags wrong");
   a_rx_frame_err: assert property (rx_done && !rx_bit |=> fe_r && rxf_r)
      else $error("missing stop bit not flagged");
   a_rx_nine_copy: assert property (rx_done && !rx_brk && !rxf_r && !char9_r
      |=> rx_nine_r == $past(rx_sh_r[7]))
      else $error("rx_bit_nine is not a copy of bit 7");
endmodule

// ---- verif/asu_remote.sv ----
// remote serial device: sends frames to the unit and captures its frames
// assumes the link shares clk_sys_i and a bit lasts BIT_CLKS clocks
`timescale 1ns/1ps
module asu_remote #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk_sys_i,
   input wire logic line_i,
   output logic line_o
);
   // the line has a pull-up, so released means high
   initial line_o = 1'b1;
   // frame given whole with the start bit in bit 0, sent lsb first
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         line_o <= f[i];
         repeat (BIT_CLKS) @(posedge clk_sys_i);
      end
      line_o <= 1'b1;
   endtask
   // mid-bit sampling from the first falling edge; ok low on timeout
   task automatic grab(input int n, output logic [11:0] v, output bit ok);
      int t;
      t = 0;
      v = '0;
      while (line_i !== 1'b0 && t < 4000) begin
         @(posedge clk_sys_i);
         t++;
      end
      ok = (t < 4000);
      repeat (BIT_CLKS / 2) @(posedge clk_sys_i);
      for (int i = 0; i < n; i++) begin
         v[i] = line_i;
         repeat (BIT_CLKS) @(posedge clk_sys_i);
      end
   endtask
endmodule

// ---- verif/async_serial_tx_rx_tb.sv ----
// self-checking bench: avalon register accesses and serial traffic
// assumes divisor 1, so one bit is 16 clocks of clk_sys_i
`timescale 1ns/1ps
`include "asu_defines.svh"
module async_serial_tx_rx_tb;
   import asu_pkg::*;
   logic clk_sys_i, rst_i, rd, wr, wt, so, soe, tirq, rirq, si, ce;
   logic [4:0] adr;
   logic [31:0] wd, q, r;
   logic [11:0] v;
   bit ok;
   int num_errors = 0;
   int checked = 0;
   int lowrun = 0;
   int lastrun = 0;
   asu_top u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
      .avs_readdata_o(q), .avs_waitrequest_o(wt), .baud_alt_tick_i(1'b0),
      .serial_in_i(si), .serial_out_o(so), .serial_out_oe_o(soe),
      .tx_irq_o(tirq), .rx_irq_o(rirq));
   asu_remote u_rem (.clk_sys_i(clk_sys_i), .line_i(so), .line_o(si));
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   // length of the last low run on the line, sampled where settled
   always @(negedge clk_sys_i) begin
      if (so === 1'b0) begin
         lowrun++;
      end else begin
         if (lowrun > 0) lastrun = lowrun;
         lowrun = 0;
      end
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // entered just after a rising edge; holds the request until waitrequest low
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (wt !== 1'b0 && n < 20);
      if (n >= 20) begin
         num_errors++;
         summarize();
      end
      @(posedge clk_sys_i);
      r = q;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys_i);
      num_errors++;
      summarize();
   end
   initial begin
      rst_i = 1'b1;
      ce = 1'b1;
      adr = 5'h00;
      rd = 1'b0;
      wr = 1'b0;
      wd = 32'h0000_0000;
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      chk(so, 1);
      chk(soe, 0);
      acc(0, `ASU_OFS_STATUS_ONE, 0);
      chk(r[`ASU_B_TXE], 1);
      acc(1, `ASU_OFS_BAUD, 32'h0000_0100);
      acc(1, `ASU_OFS_CTRL_ONE, 32'h0000_0001);
      // the enable is registered, so look once it has settled
      @(negedge clk_sys_i);
      chk(soe, 1);
      @(posedge clk_sys_i);
      acc(1, `ASU_OFS_CTRL_TWO, 32'h0000_001B);
      acc(0, `ASU_OFS_STATUS_ONE, 0);
      acc(1, `ASU_OFS_DATA_BUF, 32'h0000_00A5);
      u_rem.grab(10, v, ok);
      chk(ok, 1);
      chk(v, 12'h34A);
      chk(tirq, 1);
      $display("test tx 8-bit ended at %0t", $time);
      acc(1, `ASU_OFS_CTRL_ONE, 32'h0000_0003);
      acc(1, `ASU_OFS_CTRL_THREE, 32'h0000_0001);
      acc(0, `ASU_OFS_STATUS_ONE, 0);
      acc(1, `ASU_OFS_DATA_BUF, 32'h0000_003C);
      u_rem.grab(11, v, ok);
      chk(v, 12'h678);
      acc(1, `ASU_OFS_CTRL_ONE, 32'h0000_0005);
      repeat (3) @(posedge clk_sys_i);
      chk(so, 0);
      acc(1, `ASU_OFS_CTRL_ONE, 32'h0000_0001);
      $display("test tx 9-bit and invert ended at %0t", $time);
      // break length in short and long mode, then a mark after it
      for (int lb = 0; lb < 2; lb++) begin
         acc(1, `ASU_OFS_BAUD, 32'h0000_0100 | lb);
         acc(1, `ASU_OFS_CTRL_TWO, 32'h0000_001F);
         repeat (60) @(posedge clk_sys_i);
         // a frozen clock enable stretches the break by exactly the frozen cycles
         ce <= 1'b0;
         repeat (32) @(posedge clk_sys_i);
         ce <= 1'b1;
         acc(1, `ASU_OFS_CTRL_TWO, 32'h0000_001B);
         repeat (400) @(posedge clk_sys_i);
         chk(lastrun, 192 + 16 * lb);
         chk(so, 1);
      end
      acc(1, `ASU_OFS_BAUD, 32'h0000_0100);
      $display("test tx break ended at %0t", $time);
      u_rem.send(12'h32C, 10);
      repeat (20) @(posedge clk_sys_i);
      acc(0, `ASU_OFS_STATUS_ONE, 0);
      chk(r[`ASU_B_RXF], 1);
      chk(rirq, 1);
      acc(0, `ASU_OFS_DATA_BUF, 0);
      chk(r[7:0], 8'h96);
      acc(0, `ASU_OFS_CTRL_THREE, 0);
      chk(r[`ASU_B_RX_NINE], 1);
      u_rem.send(12'h154, 10);
      repeat (20) @(posedge clk_sys_i);
      acc(0, `ASU_OFS_STATUS_ONE, 0);
      chk(r[`ASU_B_FE], 1);
      acc(0, `ASU_OFS_DATA_BUF, 0);
      u_rem.send(12'h000, 10);
      repeat (20) @(posedge clk_sys_i);
      acc(0, `ASU_OFS_STATUS_ONE, 0);
      chk(r[2:1], 2'b11);
      acc(0, `ASU_OFS_STATUS_TWO, 0);
      chk(r[`ASU_B_BRK], 1);
      acc(0, `ASU_OFS_DATA_BUF, 0);
      chk(r[7:0], 8'h00);
      acc(0, `ASU_OFS_CTRL_THREE, 0);
      chk(r[`ASU_B_RX_NINE], 0);
      acc(1, `ASU_OFS_STATUS_TWO, 32'h0000_0001);
      acc(0, `ASU_OFS_STATUS_TWO, 0);
      chk(r[`ASU_B_BRK], 0);
      // long mode needs one more zero after the zero stop position
      acc(1, `ASU_OFS_BAUD, 32'h0000_0101);
      u_rem.send(12'h000, 11);
      repeat (20) @(posedge clk_sys_i);
      acc(0, `ASU_OFS_STATUS_TWO, 0);
      chk(r[`ASU_B_BRK], 1);
      $display("test receive ended at %0t", $time);
      acc(1, `ASU_OFS_CTRL_ONE, 32'h0000_0000);
      @(negedge clk_sys_i);
      chk(soe, 0);
      $display("test disable ended at %0t", $time);
      summarize();
   end
endmodule
